// >>> pkg/gia_regs.svh
// register offsets, field positions and reset values
`ifndef GIA_REGS_SVH
`define GIA_REGS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define GIA_NGRP        12
`define GIA_NSRC        8
`define GIA_ACK_MSB     11
`define GIA_FLAG_MSB    7

// ****************************************************************
// register offsets (16-bit word addresses)
// ****************************************************************
`define GIA_OFF_ACK     12'hCE1
`define GIA_OFF_EN_BASE 12'hCE2
`define GIA_OFF_GRP_END 12'hCF9
`define GIA_OFF_STAT    12'hD00
`define GIA_OFF_MASK    12'hD01

// ****************************************************************
// reset values
// ****************************************************************
`define GIA_RST_ACK     12'h000
`define GIA_RST_FLAG    8'h00
`define GIA_RST_EN      8'h00
`define GIA_RST_STAT    12'h000
`define GIA_RST_MASK    12'h000

`endif

// >>> pkg/gia_pkg.sv
// types shared by the group interrupt acknowledge and flag block
package gia_pkg;

  typedef logic [11:0] gia_addr_t;
  typedef logic [15:0] gia_data_t;

  typedef struct packed {
    logic      wr;
    logic      rd;
    gia_addr_t addr;
    gia_data_t wdata;
  } gia_bus_s;

  typedef struct packed {
    logic       is_ack;
    logic       is_en;
    logic       is_flag;
    logic       is_stat;
    logic       is_mask;
    logic [3:0] grp;
  } gia_dec_s;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [3:0] grp;
    logic [2:0] src;
  } gia_fetch_s;

endpackage

// >>> design/gia_prio.sv
// lowest-numbered set bit finder for vector fetch arbitration
module gia_prio (
  input  wire logic [7:0] vec,
  output logic            found,
  output logic [2:0]      idx
);

  // source 0 (bit 0) has the highest priority inside a group
  always_comb begin
    found = 1'b0;
    idx   = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (vec[i]) begin
        found = 1'b1;
        idx   = 3'(i);
      end
    end
  end

endmodule

// >>> design/gia_irq.sv
// sticky event status, mask and level interrupt output
`include "gia_regs.svh"
module gia_irq (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [11:0] evt,
  input  wire logic        wr_stat,
  input  wire logic        wr_mask,
  input  wire logic [11:0] wdata,
  output logic [11:0]      stat_q,
  output logic [11:0]      mask_q,
  output logic             irq
);

  // write one clears; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= `GIA_RST_STAT;
    end else if (ce) begin
      stat_q <= (stat_q & ~(wr_stat ? wdata : 12'h000)) | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= `GIA_RST_MASK;
    end else if (ce && wr_mask) begin
      mask_q <= wdata;
    end
  end

  assign irq = |(stat_q & mask_q);

endmodule

// >>> design/gia_top.sv
// group interrupt acknowledge, flag and enable logic with register port
`include "gia_regs.svh"
module gia_top (
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic              CLK_EN,
  input  wire logic [11:0]       REG_ADDR,
  input  wire logic [15:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic [15:0]            REG_RDATA,
  input  wire logic [11:0][7:0]  SRC_INT,
  output logic [11:0]            CPU_INT_PULSE,
  input  wire logic              CPU_FETCH,
  input  wire logic [3:0]        CPU_FETCH_GROUP,
  output logic                   FETCH_VALID,
  output logic                   FETCH_HIT,
  output logic [2:0]             FETCH_SOURCE,
  output logic                   IRQ
);

  // ****************************************************************
  // address decode
  // ****************************************************************

  // groups sit as enable/flag pairs from the enable base upward
  function automatic gia_pkg::gia_dec_s decode(input gia_pkg::gia_addr_t a);
    gia_pkg::gia_dec_s d;
    gia_pkg::gia_addr_t off;
    d   = '0;
    off = a - `GIA_OFF_EN_BASE;
    if (a == `GIA_OFF_ACK) begin
      d.is_ack = 1'b1;
    end else if (a >= `GIA_OFF_EN_BASE && a <= `GIA_OFF_GRP_END) begin
      d.grp     = off[4:1];
      d.is_en   = ~off[0];
      d.is_flag = off[0];
    end else if (a == `GIA_OFF_STAT) begin
      d.is_stat = 1'b1;
    end else if (a == `GIA_OFF_MASK) begin
      d.is_mask = 1'b1;
    end
    return d;
  endfunction

  gia_pkg::gia_bus_s   bus;
  gia_pkg::gia_dec_s   wdec;
  gia_pkg::gia_dec_s   rdec;
  gia_pkg::gia_fetch_s fetch_d;
  gia_pkg::gia_fetch_s fetch_q;

  assign bus.wr    = REG_WR;
  assign bus.rd    = REG_RD;
  assign bus.addr  = REG_ADDR;
  assign bus.wdata = REG_WDATA;
  assign wdec      = decode(bus.addr);
  assign rdec      = decode(bus.addr);

  // ****************************************************************
  // per-group state
  // ****************************************************************

  logic [7:0]  flag_q [`GIA_NGRP];
  logic [7:0]  en_q   [`GIA_NGRP];
  logic [7:0]  src_q  [`GIA_NGRP];
  logic [7:0]  clr    [`GIA_NGRP];
  logic [11:0] ack_q;
  logic [11:0] pend;
  logic [11:0] fire;
  logic [11:0] pulse_q;
  logic [11:0] ack_wr_clr;
  logic [11:0] stat_q;
  logic [11:0] mask_q;

  assign ack_wr_clr = (bus.wr && wdec.is_ack) ? bus.wdata[`GIA_ACK_MSB:0] : 12'h000;

  genvar g;
  generate
    for (g = 0; g < `GIA_NGRP; g++) begin : grp
      logic [7:0] rise;
      logic [7:0] flag_d;

      assign rise = SRC_INT[g] & ~src_q[g];

      assign pend[g] = |(flag_q[g] & en_q[g]);

      assign fire[g] = pend[g] & ~ack_q[g];

      assign clr[g] = (CPU_FETCH && fetch_d.hit && fetch_d.grp == 4'(g))
                      ? (8'h01 << fetch_d.src) : 8'h00;

      // hardware set beats writes and fetch clear
      // written zero or service clears flag
      always_comb begin
        flag_d = flag_q[g];
        if (bus.wr && wdec.is_flag && wdec.grp == 4'(g)) begin
          flag_d = bus.wdata[`GIA_FLAG_MSB:0];
        end
        flag_d = (flag_d & ~clr[g]) | rise;
      end

      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          src_q[g] <= 8'h00;
        end else if (CLK_EN) begin
          src_q[g] <= SRC_INT[g];
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          flag_q[g] <= `GIA_RST_FLAG;
        end else if (CLK_EN) begin
          flag_q[g] <= flag_d;
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          en_q[g] <= `GIA_RST_EN;
        end else if (CLK_EN && bus.wr && wdec.is_en && wdec.grp == 4'(g)) begin
          en_q[g] <= bus.wdata[`GIA_FLAG_MSB:0];
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          ack_q[g] <= 1'((`GIA_RST_ACK) >> g);
        end else if (CLK_EN) begin
          ack_q[g] <= fire[g] | (ack_q[g] & ~ack_wr_clr[g]);
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          pulse_q[g] <= 1'b0;
        end else if (CLK_EN) begin
          pulse_q[g] <= fire[g];
        end
      end
    end
  endgenerate

  assign CPU_INT_PULSE = pulse_q;

  // ****************************************************************
  // vector fetch
  // ****************************************************************

  logic [7:0] fetch_vec;
  logic       fetch_found;
  logic [2:0] fetch_idx;

  // out-of-range group numbers see nothing pending
  always_comb begin
    fetch_vec = 8'h00;
    for (int i = 0; i < `GIA_NGRP; i++) begin
      if (CPU_FETCH_GROUP == 4'(i)) begin
        fetch_vec = flag_q[i] & en_q[i];
      end
    end
  end

  gia_prio u_prio (
    .vec   (fetch_vec),
    .found (fetch_found),
    .idx   (fetch_idx)
  );

  assign fetch_d.valid = CPU_FETCH;
  assign fetch_d.hit   = fetch_found;
  assign fetch_d.grp   = CPU_FETCH_GROUP;
  assign fetch_d.src   = fetch_idx;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      fetch_q <= '0;
    end else if (CLK_EN) begin
      fetch_q.valid <= fetch_d.valid;
      fetch_q.hit   <= fetch_d.valid & fetch_d.hit;
      fetch_q.grp   <= fetch_d.grp;
      fetch_q.src   <= fetch_d.valid ? fetch_d.src : 3'h0;
    end
  end

  assign FETCH_VALID  = fetch_q.valid;
  assign FETCH_HIT    = fetch_q.hit;
  assign FETCH_SOURCE = fetch_q.src;

  // ****************************************************************
  // event status and interrupt
  // ****************************************************************

  gia_irq u_irq (
    .clk     (CORE_CLK),
    .rst     (RESET),
    .ce      (CLK_EN),
    .evt     (fire),
    .wr_stat (bus.wr && wdec.is_stat),
    .wr_mask (bus.wr && wdec.is_mask),
    .wdata   (bus.wdata[11:0]),
    .stat_q  (stat_q),
    .mask_q  (mask_q),
    .irq     (IRQ)
  );

  // ****************************************************************
  // read port
  // ****************************************************************

  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  always_comb begin
    rdata_d = 16'h0000;
    if (rdec.is_ack) begin
      rdata_d = {4'h0, ack_q};
    end else if (rdec.is_flag) begin
      for (int i = 0; i < `GIA_NGRP; i++) begin
        if (rdec.grp == 4'(i)) begin
          rdata_d = {8'h00, flag_q[i]};
        end
      end
    end else if (rdec.is_en) begin
      for (int i = 0; i < `GIA_NGRP; i++) begin
        if (rdec.grp == 4'(i)) begin
          rdata_d = {8'h00, en_q[i]};
        end
      end
    end else if (rdec.is_stat) begin
      rdata_d = {4'h0, stat_q};
    end else if (rdec.is_mask) begin
      rdata_d = {4'h0, mask_q};
    end
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rdata_q <= 16'h0000;
    end else if (CLK_EN) begin
      rdata_q <= bus.rd ? rdata_d : 16'h0000;
    end
  end

  assign REG_RDATA = rdata_q;

endmodule

// >>> testbench/gia_top_chk.sv
// port-level timing checker for the group acknowledge and flag block
`include "gia_regs.svh"
module gia_chk (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        CLK_EN,
  input wire logic [11:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [11:0] CPU_INT_PULSE,
  input wire logic        CPU_FETCH,
  input wire logic [3:0]  CPU_FETCH_GROUP,
  input wire logic        FETCH_VALID,
  input wire logic        FETCH_HIT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET || !CLK_EN);
  // groups that pulsed and have not been released since by an ack write
  logic [11:0] blk_q;
  always_ff @(posedge CORE_CLK) begin
    if (RESET)
      blk_q <= 12'h000;
    else if (CLK_EN)
      blk_q <= CPU_INT_PULSE | (blk_q & ~((REG_WR && REG_ADDR == `GIA_OFF_ACK) ?
               REG_WDATA[11:0] : 12'h000));
  end
  a_pulse_single: assert property (!(|(CPU_INT_PULSE & $past(CPU_INT_PULSE))))
    else $error("pulse longer than one cycle");
  a_ack_blocks: assert property (!(|(CPU_INT_PULSE & blk_q)))
    else $error("pulse while group acknowledge set");
  a_fetch_answer: assert property (CPU_FETCH |=> FETCH_VALID)
    else $error("fetch not answered");
  a_fetch_quiet: assert property (!CPU_FETCH |=> !FETCH_VALID && !FETCH_HIT)
    else $error("fetch result without fetch");
  a_bad_group: assert property (CPU_FETCH && CPU_FETCH_GROUP > 4'hB |=> !FETCH_HIT)
    else $error("hit on nonexistent group");
  a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data outside read slot");
  a_rsvd_zero: assert property (REG_RD |=> REG_RDATA[15:12] == 4'h0)
    else $error("reserved bits read nonzero");
  a_unmapped_zero: assert property (REG_RD && REG_ADDR > `GIA_OFF_MASK |=> REG_RDATA == 16'h0000)
    else $error("unmapped read nonzero");
endmodule
bind gia_top gia_chk i_gia_chk (.CORE_CLK, .RESET, .CLK_EN, .REG_ADDR, .REG_WDATA, .REG_WR,
  .REG_RD, .REG_RDATA, .CPU_INT_PULSE, .CPU_FETCH, .CPU_FETCH_GROUP, .FETCH_VALID, .FETCH_HIT);

// >>> testbench/gia_cpu.sv
// cpu core model: answers a group pulse seen while idle with a vector fetch, lowest group first
module gia_cpu (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] pulse,
  input  wire logic [3:0]  dly,
  input  wire logic        frc,
  input  wire logic [3:0]  frc_grp,
  output logic             fetch,
  output logic [3:0]       grp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q, g_q;
  // away from a fetch the group lines carry junk, so stale values cannot match
  assign grp = fetch ? g_q : ~g_q;
  always_ff @(posedge clk) begin
    fetch <= 1'b0;
    if (rst) begin
      cnt_q <= 4'h0;
      g_q <= 4'h0;
    end else if (frc) begin
      g_q <= frc_grp;
      cnt_q <= 4'h1;
    end else if (cnt_q > 4'h1) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (cnt_q == 4'h1) begin
      fetch <= 1'b1;
      cnt_q <= 4'h0;
    end else begin
      for (int i = 11; i >= 0; i--) begin
        if (pulse[i]) begin
          g_q <= 4'(i);
          cnt_q <= dly;
        end
      end
    end
  end
endmodule

// >>> testbench/gia_top_tb.sv
// self-checking bench for the group acknowledge and flag block
`include "gia_regs.svh"
module gia_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, rst, wr, rd, fetch, hit, valid, irq, frc, lhit, ce;
  logic [11:0]      addr, pulse;
  logic [15:0]      wdata, rdata;
  logic [11:0][7:0] src;
  logic [3:0]       fgrp, fg, dly;
  logic [2:0]       fsrc, lsrc;
  int               bad_count, n_tests, cyc;
  gia_top i_gia_top (.CORE_CLK(clk), .RESET(rst), .CLK_EN(ce), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SRC_INT(src),
    .CPU_INT_PULSE(pulse), .CPU_FETCH(fetch), .CPU_FETCH_GROUP(fgrp), .FETCH_VALID(valid),
    .FETCH_HIT(hit), .FETCH_SOURCE(fsrc), .IRQ(irq));
  gia_cpu i_gia_cpu (.clk(clk), .rst(rst), .pulse(pulse), .dly(dly), .frc(frc),
    .frc_grp(fg), .fetch(fetch), .grp(fgrp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********
  // monitors and helpers
  // ********
  always @(posedge clk) begin
    if (valid) begin
      lhit <= hit;
      lsrc <= fsrc;
    end
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic err(input string m);
    bad_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    n_tests++;
    if (rdata !== e) err("read data mismatch");
  endtask
  // a pulse on any other group line counts as a fault too
  task automatic pulse_chk(input int g, input logic e);
    logic got, oth;
    got = 1'b0;
    oth = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      got |= pulse[g];
      oth |= |(pulse & ~(12'h001 << g));
    end
    n_tests++;
    if (got !== e || oth !== 1'b0) err("interrupt pulse mismatch");
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    rd_reg(`GIA_OFF_ACK, 16'h0000);
    rd_reg(`GIA_OFF_EN_BASE + 12'h001, 16'h0000);
    wr_reg(12'hD02, 16'hFFFF);
    rd_reg(12'hD02, 16'h0000);
  endtask
  task automatic t_group(input int g);
    logic [11:0] fa;
    logic [15:0] ab;
    int s;
    fa = `GIA_OFF_EN_BASE + 12'(2 * g + 1);
    ab = 16'h0001 << g;
    s = g % 7;
    dly <= g[0] ? 4'h4 : 4'h1;
    wr_reg(fa - 12'h001, 16'h00FF);
    @(posedge clk);
    src[g][s] <= 1'b1;
    src[g][7] <= 1'b1;
    pulse_chk(g, 1'b1);
    rd_reg(`GIA_OFF_ACK, ab);
    n_tests++;
    if (lhit !== 1'b1 || lsrc !== 3'(s)) err("fetch result mismatch");
    rd_reg(fa, 16'h0080);
    pulse_chk(g, 1'b0);
    wr_reg(`GIA_OFF_ACK, 16'h0000);
    rd_reg(`GIA_OFF_ACK, ab);
    wr_reg(`GIA_OFF_ACK, ab);
    pulse_chk(g, 1'b1);
    rd_reg(fa, 16'h0000);
    wr_reg(`GIA_OFF_ACK, ab);
    src[g] <= 8'h00;
  endtask
  task automatic t_irq();
    rd_reg(`GIA_OFF_STAT, 16'h0FFF);
    n_tests++;
    if (irq !== 1'b1) err("irq low");
    wr_reg(`GIA_OFF_MASK, 16'h0000);
    #1;
    n_tests++;
    if (irq !== 1'b0) err("irq not masked");
    wr_reg(`GIA_OFF_MASK, 16'h0FFF);
    wr_reg(`GIA_OFF_STAT, 16'h0FFF);
    rd_reg(`GIA_OFF_STAT, 16'h0000);
    n_tests++;
    if (irq !== 1'b0) err("irq not cleared");
  endtask
  // a write taken while the clock enable is low must not land
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`GIA_OFF_MASK, 16'h0000);
    ce <= 1'b1;
    rd_reg(`GIA_OFF_MASK, 16'h0FFF);
  endtask
  task automatic t_flag();
    logic [11:0] fa;
    fa = `GIA_OFF_EN_BASE + 12'h017;
    wr_reg(fa - 12'h001, 16'h0000);
    wr_reg(fa, 16'hFFFF);
    pulse_chk(11, 1'b0);
    rd_reg(fa, 16'h00FF);
    // clear with a plain write, never read-modify-write
    wr_reg(fa, 16'h0000);
    rd_reg(fa, 16'h0000);
    @(posedge clk);
    src[11][3] <= 1'b1;
    wr <= 1'b1;
    addr <= fa;
    wdata <= 16'h0000;
    @(posedge clk);
    wr <= 1'b0;
    rd_reg(fa, 16'h0008);
    wr_reg(fa - 12'h001, 16'h0008);
    pulse_chk(11, 1'b1);
    wr_reg(`GIA_OFF_ACK, 16'h0800);
    src[11] <= 8'h00;
  endtask
  task automatic t_badfetch();
    @(posedge clk);
    frc <= 1'b1;
    fg <= 4'hC;
    @(posedge clk);
    frc <= 1'b0;
    repeat (4) @(posedge clk);
    n_tests++;
    if (lhit !== 1'b0) err("fetch hit on bad group");
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {wr, rd, frc, fg, addr, wdata} = '0;
    src = '0;
    dly = 4'h1;
    {bad_count, n_tests, cyc} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    wr_reg(`GIA_OFF_MASK, 16'h0FFF);
    for (int g = 0; g < 12; g++) t_group(g);
    t_irq();
    t_freeze();
    t_flag();
    t_badfetch();
    print_verdict();
  end
endmodule
